// ==== hdl/sd_host_event_status_mask.sv ====
// Event status, mask and interrupt logic of the card host controller
// Summary of operation
// - Write data CRC error sets status-two bit 7
// - Read data CRC error sets status-two bit 6
// - Response CRC error sets status-two bit 5
// - Data access timeout sets status-two bit 4
// - Remaining count reaching zero issues automatic CMD12
// - Automatic CMD12 response sets status-two bit 3
// - Response timeout sets status-two bit 2
// - Command done, or command sent, sets bit 1
// - Card insert or remove sets status-one bit 7
// - Each finished block sets status-one bit 5
// - Whole transfer finished sets status-one bit 4
// - Slot bit shows card, zero unless detect selected
// - Write-protect bit: zero protected, one writable
// - Event flags clear by writing one
// - Mask-two bits read/write, reset zero; status resets zero
// - Mask-two bit 3 gates auto stop interrupt
// - Block length bit 15 gates all interrupts
// - Bit 13 selects detect pin, bit 12 polarity
// - Mask-one bits 7, 5, 4 gate their events
// - Remaining count resets FFFFh, ends at 0000h
`timescale 1ns/1ps
`default_nettype none
`include "sd_irq_consts.svh"

module sd_host_event_status_mask
  import sd_irq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire engine_events_t events,
  input wire logic card_detect_pin,
  input wire logic write_protect_pin,
  output logic auto_stop_req,
  output logic irq
);

  // Read decode of the byte register map
  // Reads have no side effects, so software may poll the status bytes freely
  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input logic [15:0] blk_len,
    input logic [15:0] blk_cnt,
    input logic [15:0] cur_cnt,
    input logic [7:0] mask_one,
    input logic [7:0] mask_two,
    input logic [7:0] status_one,
    input logic [7:0] status_two,
    input logic [7:0] ext_ctrl
  );
    logic [7:0] data;
    data = `RST_BYTE;
    if (addr == `OFS_BLK_LEN_LO) begin
      data = blk_len[7:0];
    end else if (addr == `OFS_BLK_LEN_HI) begin
      data = blk_len[15:8];
    end else if (addr == `OFS_BLK_CNT_LO) begin
      data = blk_cnt[7:0];
    end else if (addr == `OFS_BLK_CNT_HI) begin
      data = blk_cnt[15:8];
    end else if (addr == `OFS_CUR_CNT_LO) begin
      data = cur_cnt[7:0];
    end else if (addr == `OFS_CUR_CNT_HI) begin
      data = cur_cnt[15:8];
    end else if (addr == `OFS_MASK_ONE) begin
      data = mask_one;
    end else if (addr == `OFS_MASK_TWO) begin
      data = mask_two;
    end else if (addr == `OFS_STATUS_ONE) begin
      data = status_one;
    end else if (addr == `OFS_STATUS_TWO) begin
      data = status_two;
    end else if (addr == `OFS_EXT_CTRL) begin
      data = ext_ctrl;
    end
    return data;
  endfunction

  function automatic logic wr_hit(input reg_req_t req, input logic [7:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction

  // Pin synchronisers and detect tracking
  logic cd_meta_reg, cd_sync_reg, wp_meta_reg, wp_sync_reg;
  logic cd_meta_next, cd_sync_next, wp_meta_next, wp_sync_next;
  logic present_prev_reg, present_prev_next;
  logic primed_reg, primed_next;

  // Software-visible registers
  logic [15:0] blk_len_reg, blk_len_next;
  logic [15:0] blk_cnt_reg, blk_cnt_next;
  logic [15:0] cur_cnt_reg, cur_cnt_next;
  logic [7:0] mask_one_reg, mask_one_next;
  logic [7:0] mask_two_reg, mask_two_next;
  logic [7:0] s1_evt_reg, s1_evt_next;
  logic [7:0] s2_evt_reg, s2_evt_next;
  logic [7:0] ext_ctrl_reg, ext_ctrl_next;
  logic [7:0] rdata_reg, rdata_next;

  // Block count sequencing
  count_state_t cnt_state_reg, cnt_state_next;
  logic stop_req_reg, stop_req_next;
  logic irq_reg, irq_next;

  logic detect_sel, card_present, slot_bit;
  logic [7:0] s1_set, s2_set, s1_clr, s2_clr, status_one_view;

  assign detect_sel = blk_len_reg[`BL_DETECT_SEL_BIT];
  // Polarity 0 means a low pin marks a card in the slot
  assign card_present = blk_len_reg[`BL_DETECT_POL_BIT] ? cd_sync_reg : ~cd_sync_reg;
  assign slot_bit = detect_sel & card_present;
  assign status_one_view = s1_evt_reg
                         | ({7'h00, slot_bit} << `S1_SLOT_BIT)
                         | ({7'h00, wp_sync_reg} << `S1_WRITE_OK_BIT);

  always_comb begin
    cd_meta_next = card_detect_pin;
    cd_sync_next = cd_meta_reg;
    wp_meta_next = write_protect_pin;
    wp_sync_next = wp_meta_reg;
    present_prev_next = slot_bit;
    // The first cycle after reset only loads the history, so no false change is seen
    primed_next = 1'b1;
  end

  // Event sets and software clears
  always_comb begin
    s1_set = `RST_BYTE;
    s2_set = `RST_BYTE;
    s1_set[`S1_CARD_CHANGE_BIT] = primed_reg && detect_sel
                                  && (slot_bit != present_prev_reg);
    s1_set[`S1_BLOCK_DONE_BIT] = events.block_done;
    s1_set[`S1_XFER_DONE_BIT] = events.xfer_done;
    s2_set[`S2_WR_CRC_BIT] = events.wr_crc_err;
    s2_set[`S2_RD_CRC_BIT] = events.rd_crc_err;
    s2_set[`S2_RSP_CRC_BIT] = events.rsp_crc_err;
    s2_set[`S2_DATA_TIMEOUT_BIT] = events.data_timeout;
    s2_set[`S2_AUTO_STOP_BIT] = events.auto_stop_rsp;
    s2_set[`S2_RSP_TIMEOUT_BIT] = events.rsp_timeout;
    s2_set[`S2_CMD_DONE_BIT] = events.cmd_done;
    s1_clr = wr_hit(reg_req, `OFS_STATUS_ONE) ? reg_req.wdata : `RST_BYTE;
    s2_clr = wr_hit(reg_req, `OFS_STATUS_TWO) ? reg_req.wdata : `RST_BYTE;
    // A set in the clearing cycle survives, so no event is lost
    s1_evt_next = ((s1_evt_reg & ~s1_clr) | s1_set) & `S1_EVENT_MASK;
    s2_evt_next = ((s2_evt_reg & ~s2_clr) | s2_set) & `S2_EVENT_MASK;
  end

  // Plain read/write control registers
  always_comb begin
    blk_len_next = blk_len_reg;
    blk_cnt_next = blk_cnt_reg;
    mask_one_next = mask_one_reg;
    mask_two_next = mask_two_reg;
    ext_ctrl_next = ext_ctrl_reg;
    if (wr_hit(reg_req, `OFS_BLK_LEN_LO)) begin
      blk_len_next[7:0] = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_BLK_LEN_HI)) begin
      blk_len_next[15:8] = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_BLK_CNT_LO)) begin
      blk_cnt_next[7:0] = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_BLK_CNT_HI)) begin
      blk_cnt_next[15:8] = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_MASK_ONE)) begin
      mask_one_next = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_MASK_TWO)) begin
      mask_two_next = reg_req.wdata;
    end else if (wr_hit(reg_req, `OFS_EXT_CTRL)) begin
      ext_ctrl_next = reg_req.wdata;
    end
    rdata_next = rdata_reg;
    if (reg_req.rd) begin
      rdata_next = read_mux(reg_req.addr, blk_len_reg, blk_cnt_reg, cur_cnt_reg,
                            mask_one_reg, mask_two_reg, status_one_view,
                            s2_evt_reg, ext_ctrl_reg);
    end
  end

  // Remaining block count and automatic stop command
  always_comb begin
    cnt_state_next = cnt_state_reg;
    cur_cnt_next = cur_cnt_reg;
    stop_req_next = 1'b0;
    case (cnt_state_reg)
      CNT_IDLE: begin
        if (events.multi_start) begin
          cur_cnt_next = blk_cnt_reg;
          cnt_state_next = CNT_RUN;
        end
      end
      CNT_RUN: begin
        // A count of FFFFh runs until software stops the transfer
        if (events.block_done && blk_cnt_reg != `CNT_INFINITE
            && cur_cnt_reg != `RST_WORD) begin
          cur_cnt_next = cur_cnt_reg - 16'h0001;
        end
        if (cur_cnt_reg == `RST_WORD && blk_cnt_reg != `CNT_INFINITE) begin
          stop_req_next = ext_ctrl_reg[`EXT_AUTO_STOP_BIT];
          cnt_state_next = CNT_STOP;
        end else if (events.xfer_done) begin
          cnt_state_next = CNT_IDLE;
        end
      end
      CNT_STOP: begin
        // Hold at zero until the stop response or the transfer end closes the command
        if (events.auto_stop_rsp || events.xfer_done) begin
          cnt_state_next = CNT_IDLE;
        end
      end
      default: begin
        cnt_state_next = CNT_IDLE;
      end
    endcase
  end

  // Level interrupt: it stays up until software clears or masks every source, or clears block length bit 15
  always_comb begin
    irq_next = blk_len_reg[`BL_MASTER_IRQ_BIT]
             && (|(s1_evt_reg & mask_one_reg & `S1_EVENT_MASK)
                 || |(s2_evt_reg & mask_two_reg & `S2_EVENT_MASK));
  end

  // Synchroniser stages and detect history
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cd_meta_reg <= 1'b0;
      cd_sync_reg <= 1'b0;
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
      present_prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      cd_meta_reg <= cd_meta_next;
      cd_sync_reg <= cd_sync_next;
      wp_meta_reg <= wp_meta_next;
      wp_sync_reg <= wp_sync_next;
      present_prev_reg <= present_prev_next;
      primed_reg <= primed_next;
    end
  end

  // Status flags; cleared by reset so no stale event survives it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s1_evt_reg <= `RST_BYTE;
      s2_evt_reg <= `RST_BYTE;
    end else begin
      s1_evt_reg <= s1_evt_next;
      s2_evt_reg <= s2_evt_next;
    end
  end

  // Control registers and read data
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      blk_len_reg <= `RST_WORD;
      blk_cnt_reg <= `RST_WORD;
      mask_one_reg <= `RST_BYTE;
      mask_two_reg <= `RST_BYTE;
      ext_ctrl_reg <= `RST_BYTE;
      rdata_reg <= `RST_BYTE;
    end else begin
      blk_len_reg <= blk_len_next;
      blk_cnt_reg <= blk_cnt_next;
      mask_one_reg <= mask_one_next;
      mask_two_reg <= mask_two_next;
      ext_ctrl_reg <= ext_ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Block count sequencing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cur_cnt_reg <= `RST_CUR_CNT;
      cnt_state_reg <= CNT_IDLE;
      stop_req_reg <= 1'b0;
    end else begin
      cur_cnt_reg <= cur_cnt_next;
      cnt_state_reg <= cnt_state_next;
      stop_req_reg <= stop_req_next;
    end
  end

  // The interrupt line only moves on a clock edge, so it never glitches
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign auto_stop_req = stop_req_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// ==== hdl/sd_irq_consts.svh ====
// Register offsets, field positions, event masks and reset values of the event status block
`ifndef SD_IRQ_CONSTS_SVH
`define SD_IRQ_CONSTS_SVH

`define OFS_BLK_LEN_LO 8'h0c
`define OFS_BLK_LEN_HI 8'h0d
`define OFS_BLK_CNT_LO 8'h0e
`define OFS_BLK_CNT_HI 8'h0f
`define OFS_CUR_CNT_LO 8'h20
`define OFS_CUR_CNT_HI 8'h21
`define OFS_MASK_ONE 8'h24
`define OFS_MASK_TWO 8'h25
`define OFS_STATUS_ONE 8'h28
`define OFS_STATUS_TWO 8'h29
`define OFS_EXT_CTRL 8'h34

`define BL_MASTER_IRQ_BIT 15
`define BL_DETECT_SEL_BIT 13
`define BL_DETECT_POL_BIT 12
`define EXT_AUTO_STOP_BIT 0

`define S1_CARD_CHANGE_BIT 7
`define S1_BLOCK_DONE_BIT 5
`define S1_XFER_DONE_BIT 4
`define S1_SLOT_BIT 3
`define S1_WRITE_OK_BIT 1
`define S1_EVENT_MASK 8'hb0

`define S2_WR_CRC_BIT 7
`define S2_RD_CRC_BIT 6
`define S2_RSP_CRC_BIT 5
`define S2_DATA_TIMEOUT_BIT 4
`define S2_AUTO_STOP_BIT 3
`define S2_RSP_TIMEOUT_BIT 2
`define S2_CMD_DONE_BIT 1
`define S2_EVENT_MASK 8'hfe

`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_CUR_CNT 16'hffff
`define CNT_INFINITE 16'hffff

`endif

// ==== hdl/sd_irq_pkg.sv ====
// Types shared by the event status block and its surroundings
package sd_irq_pkg;

  // One-cycle pulses from the command and data engines
  typedef struct packed {
    logic wr_crc_err;
    logic rd_crc_err;
    logic rsp_crc_err;
    logic data_timeout;
    logic auto_stop_rsp;
    logic rsp_timeout;
    logic cmd_done;
    logic block_done;
    logic xfer_done;
    logic multi_start;
  } engine_events_t;

  // Byte-wide register port of the card host register space
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN = 2'b01,
    CNT_STOP = 2'b10
  } count_state_t;

endpackage

// ==== bench/sd_event_checker_sva.sv ====
// Port-level assertions for the event status block
`timescale 1ns/1ps
`default_nettype none
module sd_event_checker
  import sd_irq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire engine_events_t events,
  input wire logic auto_stop_req,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [7:0] ad);
    reg_req.rd && reg_req.addr == ad;
  endsequence
  // Event, one cycle with no write to that status byte, then a read of it
  sequence s_evt_then_rd(ev, logic [7:0] ad);
    ev ##1 !(reg_req.wr && reg_req.addr == ad) ##1 s_rd(ad);
  endsequence
  a_wr_crc_seen: assert property (s_evt_then_rd(events.wr_crc_err, 8'h29) |=> reg_rdata[7])
    else $error("write crc flag missing");
  a_rsp_crc_seen: assert property (s_evt_then_rd(events.rsp_crc_err, 8'h29) |=> reg_rdata[5])
    else $error("response crc flag missing");
  a_cmd_done_seen: assert property (s_evt_then_rd(events.cmd_done, 8'h29) |=> reg_rdata[1])
    else $error("command done flag missing");
  a_block_done_seen: assert property (s_evt_then_rd(events.block_done, 8'h28) |=> reg_rdata[5])
    else $error("block done flag missing");
  a_stop_one_cycle: assert property (auto_stop_req |=> !auto_stop_req)
    else $error("stop request longer than one cycle");
  a_status_spare_zero: assert property (s_rd(8'h29) |=> !reg_rdata[0])
    else $error("spare status bit not zero");
  a_master_gates_irq: assert property (reg_req.wr && reg_req.addr == 8'h0d && !reg_req.wdata[7]
    |=> ##1 !irq) else $error("irq stays with master off");
  a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // Checked during reset too, so the default disable is overridden here
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !irq && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ==== bench/sd_card_model.sv ====
// Behavioural removable card: detect and lock switches, answers the stop command
`timescale 1ns/1ps
`default_nettype none
module sd_card_model (
  input wire logic core_clk,
  input wire logic card_present,
  input wire logic write_locked,
  input wire logic auto_stop_req,
  output logic card_detect_pin,
  output logic write_protect_pin,
  output logic stop_rsp
);
  logic [2:0] rsp_dly = 3'h0;
  // An inserted card pulls the detect line low
  assign card_detect_pin = !card_present;
  assign write_protect_pin = !write_locked;
  // The response comes back some clocks later, never in the request cycle
  always_ff @(posedge core_clk) rsp_dly <= {rsp_dly[1:0], auto_stop_req};
  assign stop_rsp = rsp_dly[2];
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the event status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sd_irq_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t reg_req = '0;
  engine_events_t ev_drv = '0;
  engine_events_t events;
  logic card_present = 1'b1;
  logic write_locked = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] reg_rdata, a, b, base, v;
  logic auto_stop_req, irq, cd_pin, wp_pin, stop_rsp;
  logic [7:0] exp_q[$];
  int failures = 0;
  int comparisons = 0;
  int stop_pulses = 0;
  assign events = ev_drv | engine_events_t'({4'h0, stop_rsp, 5'h00});
  always #20 core_clk = ~core_clk;
  sd_host_event_status_mask u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .events(events), .card_detect_pin(cd_pin),
    .write_protect_pin(wp_pin), .auto_stop_req(auto_stop_req), .irq(irq));
  sd_card_model u_card (.core_clk(core_clk), .card_present(card_present),
    .write_locked(write_locked), .auto_stop_req(auto_stop_req), .card_detect_pin(cd_pin),
    .write_protect_pin(wp_pin), .stop_rsp(stop_rsp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data lands after the strobe edge, so it is taken at the next edge
  always @(posedge core_clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front(), "read data");
    if (auto_stop_req) stop_pulses++;
    rd_pend <= reg_req.rd;
  end
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{addr: ad, wr: w, rd: !w, wdata: d};
    if (!w) exp_q.push_back(d);
    @(negedge core_clk);
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
  endtask
  task automatic pulse(input logic [9:0] e);
    @(negedge core_clk);
    ev_drv = engine_events_t'(e);
    @(negedge core_clk);
    ev_drv = '0;
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(38661));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    acc(0, 8'h25, 8'h00);
    acc(0, 8'h28, 8'h02);
    acc(0, 8'h29, 8'h00);
    acc(0, 8'h20, 8'hff);
    acc(0, 8'h26, 8'h00);
    v = 8'($urandom);
    acc(1, 8'h25, v);
    acc(0, 8'h25, v);
    acc(1, 8'h24, 8'hb0);
    acc(1, 8'h25, 8'hfe);
    acc(1, 8'h0d, 8'ha0);
    acc(1, 8'h28, 8'hff);
    for (int j = 1; j < 10; j++) begin
      a = j < 3 ? 8'h28 : 8'h29;
      b = j < 3 ? 8'h08 << j : 8'h01 << (j - 2);
      base = j < 3 ? 8'h0a : 8'h00;
      pulse(10'h001 << j);
      acc(0, a, base | b);
      chk({7'h0, irq}, 8'h01, "irq");
      acc(1, a, 8'h00);
      acc(0, a, base | b);
      acc(1, a, b);
      acc(0, a, base);
      chk({7'h0, irq}, 8'h00, "irq");
    end
    acc(1, 8'h25, 8'h00);
    pulse(10'h008);
    chk({7'h0, irq}, 8'h00, "irq");
    acc(1, 8'h25, 8'hfe);
    acc(1, 8'h28, 8'h00);
    chk({7'h0, irq}, 8'h01, "irq");
    acc(1, 8'h0d, 8'h20);
    acc(1, 8'h28, 8'h00);
    chk({7'h0, irq}, 8'h00, "irq");
    acc(1, 8'h29, 8'h02);
    card_present = 1'b0;
    write_locked = 1'b1;
    repeat (5) @(negedge core_clk);
    acc(0, 8'h28, 8'h80);
    acc(1, 8'h28, 8'h80);
    card_present = 1'b1;
    repeat (5) @(negedge core_clk);
    acc(0, 8'h28, 8'h88);
    acc(1, 8'h28, 8'h80);
    acc(1, 8'h0e, 8'h02);
    acc(1, 8'h34, 8'h01);
    pulse(10'h001);
    acc(0, 8'h20, 8'h02);
    pulse(10'h004);
    pulse(10'h004);
    repeat (8) @(negedge core_clk);
    acc(0, 8'h20, 8'h00);
    acc(0, 8'h29, 8'h08);
    chk(8'(stop_pulses), 8'h01, "stop requests");
    acc(1, 8'h20, 8'h55);
    acc(0, 8'h20, 8'h00);
    final_report();
  end
endmodule
bind sd_host_event_status_mask sd_event_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .events(events), .auto_stop_req(auto_stop_req),
  .irq(irq));
`default_nettype wire
